// ### pcs_pkg.sv
// constants, types and register map of the press cyclic start monitor
// assumes a 250 mhz system clock and an apb register port
package pcs_pkg;

   // timing: all supervision runs on a millisecond tick
   localparam int unsigned CLK_KHZ        = 250000;
   localparam int unsigned TICK_MS        = 1;
   localparam int unsigned MS_CYCLES      = CLK_KHZ * TICK_MS;
   localparam logic [14:0] PULSE_SHORT_MS = 15'h0064;   // 100 ms
   localparam logic [14:0] PULSE_LONG_MS  = 15'h015e;   // 350 ms
   localparam logic [14:0] REARM_MAX_MS   = 15'h7530;   // 30 s
   localparam logic [14:0] NO_MAX_MS      = 15'h7fff;

   // register byte offsets
   localparam logic [11:0] CFG_OFS  = 12'h000;
   localparam logic [11:0] SUPV_OFS = 12'h004;
   localparam logic [11:0] STAT_OFS = 12'h008;

   // configuration register, bits [12:0]; two-bit settings hold their setting number
   typedef struct packed {
      logic       err_en;        // [12] fault indicator present
      logic       start_upper;   // [11] start only at upper stroke position
      logic       guard_long;    // [10] 350 ms least intervention
      logic       rearm_long;    // [9]  350 ms least rearm pulse
      logic [1:0] rearm_lock;    // [8:7] 1 none, 2 always, 3 after stop off top
      logic [1:0] first_start;   // [6:5] 1 at upper position, 2 after launch
      logic [1:0] permit2_mode;  // [4:3] 1 unused, 2 every start, 3 first start
      logic [2:0] interv_m1;     // [2:0] interventions per start minus one
   } pcs_cfg_t;
   localparam int unsigned CFG_W   = 13;
   localparam logic [12:0] CFG_RST = 13'h0128;
   localparam int unsigned SUPV_W  = 20;   // supervision time in ms, 0 is off
   localparam logic [1:0]  SET_1   = 2'h1;
   localparam logic [1:0]  SET_2   = 2'h2;
   localparam logic [1:0]  SET_3   = 2'h3;

   typedef enum logic [3:0] {
      ST_LOCK  = 4'h1,
      ST_COUNT = 4'h2,
      ST_REARM = 4'h4,
      ST_RUN   = 4'h8
   } pcs_state_t;

   // synchronised pins
   typedef struct packed {
      logic permit1;
      logic permit2;
      logic guard;
      logic upper;
      logic launch;
      logic rearm;
   } pcs_pins_t;

endpackage

// ### pcs_width_q.sv
// pulse width qualifier: reports the end of an active phase of valid length
// assumes a synchronised level and a one-cycle millisecond tick
`timescale 1ns/10ps
module pcs_width_q (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // phase to measure
   input  wire logic        level_in,
   input  wire logic        tick_in,
   input  wire logic [14:0] min_ms_in,
   input  wire logic [14:0] max_ms_in,
   // qualified phase end
   output logic             done_out
);
   logic [14:0] cnt_ff;
   logic [14:0] nxt_cnt;
   logic        prev_ff;
   logic        done_ff;
   logic        nxt_done;

   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_done = 1'b0;
      if (!level_in) begin
         nxt_cnt = 15'h0000;
      end else if (tick_in && cnt_ff != 15'h7fff) begin
         nxt_cnt = cnt_ff + 15'h0001;   // saturates, so a stuck level never wraps
      end
      if (prev_ff && !level_in && cnt_ff >= min_ms_in && cnt_ff <= max_ms_in) begin
         nxt_done = 1'b1;
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff  <= 15'h0000;
         prev_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         prev_ff <= level_in;
         done_ff <= nxt_done;
      end
   end

   assign done_out = done_ff;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   width_min_a: assert property (done_ff |-> $past(cnt_ff) >= $past(min_ms_in))
      else $error("qualified phase shorter than minimum");
   width_max_a: assert property ($rose(done_ff) |-> $past(cnt_ff) <= $past(max_ms_in))
      else $error("qualified phase longer than maximum");
endmodule // pcs_width_q

// ### pcs_monitor.sv
// press cyclic start monitor: counts guard interventions and grants stroke permit
// assumes asynchronous pins and an apb master on the system clock
//
// Operation
// - secondary permit: unused, every start, first start
// - first stroke after upper position or launch
// - rearm lock: none, always, after off-top stop
// - fault output on overrun or unexpected intervention
// - intervention needed while interventions remain
// - rearm needed when rearm lock engaged
// - overrun when supervision time exceeded
// - guard breach on unpermitted intervention
// - off-position stop flag until upper reached
// - intervention counts on high-low-high guard
// - permit and guard high raise intervention needed
// - following intervention raises press permit
// - rearm lock demands complete start sequence
// - complete start after permit loss, breach, overrun, power-up
// - breach holds: guard low, unmuted, off top
// - lock one: breach recovers without rearm
// - lock three: launch phase recovers without rearm
// - ignore interventions below least time
// - rearm pulse: least high time, 30 s cap
// - one to eight interventions per start
// - upper rising edge restarts intervention count
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module pcs_monitor #(
   parameter int unsigned MS_CYCLES_P = pcs_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        clock_in,
   input  wire logic        rst_in,
   // apb slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // press pins, asynchronous
   input  wire logic        permit1_in,
   input  wire logic        permit2_in,
   input  wire logic        guard_in,
   input  wire logic        upper_in,
   input  wire logic        launch_in,
   input  wire logic        rearm_in,
   // press outputs
   output logic             permit_out,
   output logic             interv_needed_out,
   output logic             rearm_needed_out,
   output logic             overrun_out,
   output logic             breach_out,
   output logic             off_pos_out,
   output logic             fault_out
);
   pcs_pkg::pcs_pins_t  meta_ff, pins_ff, last_ff;
   pcs_pkg::pcs_cfg_t   cfg_ff, nxt_cfg;
   logic [pcs_pkg::SUPV_W-1:0] supv_ff, nxt_supv, tmr_ff, nxt_tmr;
   logic [31:0]         rd_ff, nxt_rd;
   logic [17:0]         div_ff, nxt_div;
   logic                tick;
   pcs_pkg::pcs_state_t st_ff, nxt_st;
   logic [2:0]          cnt_ff, nxt_cnt;
   logic                full_ff, nxt_full, need_rearm_ff, nxt_need_rearm;
   logic                left_ff, nxt_left, unexp_ff, nxt_unexp;
   logic                permit_ff, nxt_permit, intv_ff, nxt_intv, rearm_ff, nxt_rearm;
   logic                overrun_ff, nxt_overrun, breach_ff, nxt_breach;
   logic                off_ff, nxt_off, fault_ff, nxt_fault;
   logic                guard_done, rearm_done, mute, breach_cond, p2_ok, fail;
   logic                lock_stop, upper_rise, over_now, map_hit;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == pcs_pkg::CFG_OFS) || (a == pcs_pkg::SUPV_OFS) ||
                  (a == pcs_pkg::STAT_OFS);
   endfunction

   // apb: zero wait, read data captured in setup phase
   assign map_hit     = is_mapped(paddr_in);
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !map_hit;
   assign prdata_out  = rd_ff;

   always_comb begin
      nxt_cfg  = cfg_ff;
      nxt_supv = supv_ff;
      nxt_rd   = rd_ff;
      if (psel_in && penable_in && pwrite_in) begin
         if (paddr_in == pcs_pkg::CFG_OFS) begin
            nxt_cfg = pcs_pkg::pcs_cfg_t'(pwdata_in[pcs_pkg::CFG_W-1:0]);
         end
         if (paddr_in == pcs_pkg::SUPV_OFS) begin
            nxt_supv = pwdata_in[pcs_pkg::SUPV_W-1:0];
         end
      end
      if (psel_in && !penable_in) begin
         unique case (paddr_in)
            pcs_pkg::CFG_OFS:  nxt_rd = {19'h00000, cfg_ff};
            pcs_pkg::SUPV_OFS: nxt_rd = {12'h000, supv_ff};
            pcs_pkg::STAT_OFS: nxt_rd = {17'h00000, st_ff, cnt_ff, 1'b0, permit_ff, intv_ff,
                                         rearm_ff, overrun_ff, breach_ff, off_ff,
                                         fault_ff};
            default:           nxt_rd = 32'h00000000;
         endcase
      end
   end

   // millisecond tick
   always_comb begin
      tick    = (div_ff == 18'(MS_CYCLES_P - 1));
      nxt_div = tick ? 18'h00000 : div_ff + 18'h00001;
   end

   // intervention: guard low phase of least length, ended by guard high
   pcs_width_q u_guard_q (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .level_in  (!pins_ff.guard),
      .tick_in   (tick),
      .min_ms_in (cfg_ff.guard_long ? pcs_pkg::PULSE_LONG_MS : pcs_pkg::PULSE_SHORT_MS),
      .max_ms_in (pcs_pkg::NO_MAX_MS),
      .done_out  (guard_done)
   );

   pcs_width_q u_rearm_q (
      .clock_in  (clock_in),
      .rst_in    (rst_in),
      .level_in  (pins_ff.rearm),
      .tick_in   (tick),
      .min_ms_in (cfg_ff.rearm_long ? pcs_pkg::PULSE_LONG_MS : pcs_pkg::PULSE_SHORT_MS),
      .max_ms_in (pcs_pkg::REARM_MAX_MS),
      .done_out  (rearm_done)
   );

   always_comb begin
      mute        = (cfg_ff.first_start == pcs_pkg::SET_2) && pins_ff.launch;
      breach_cond = !pins_ff.guard && !mute && !pins_ff.upper;
      p2_ok       = (cfg_ff.permit2_mode == pcs_pkg::SET_2 ||
                     (cfg_ff.permit2_mode == pcs_pkg::SET_3 && full_ff)) ?
                    pins_ff.permit2 : 1'b1;
      over_now    = (supv_ff != '0) && (tmr_ff >= supv_ff);
      // lock one never locks; lock three spares a stop in the launch phase
      lock_stop   = (cfg_ff.rearm_lock == pcs_pkg::SET_2) ||
                    (cfg_ff.rearm_lock == pcs_pkg::SET_3 && !pins_ff.launch &&
                     !pins_ff.upper);
      upper_rise  = pins_ff.upper && !last_ff.upper;
      fail        = !pins_ff.permit1 || overrun_ff || (st_ff == pcs_pkg::ST_RUN &&
                    breach_cond);
   end

   always_comb begin
      nxt_st         = st_ff;
      nxt_cnt        = cnt_ff;
      nxt_full       = full_ff;
      nxt_need_rearm = need_rearm_ff;
      nxt_left       = left_ff;
      nxt_unexp      = unexp_ff;
      nxt_tmr        = tmr_ff;
      nxt_overrun    = overrun_ff || (over_now && st_ff != pcs_pkg::ST_RUN &&
                                      st_ff != pcs_pkg::ST_LOCK);
      nxt_off        = off_ff && !pins_ff.upper;
      if (tick && nxt_tmr != '1) begin
         nxt_tmr = tmr_ff + 20'h00001;
      end
      unique case (st_ff)
         pcs_pkg::ST_LOCK: begin
            if (pins_ff.permit1 && pins_ff.guard && !off_ff && !breach_ff) begin
               nxt_st      = pcs_pkg::ST_COUNT;
               nxt_cnt     = 3'h0;
               nxt_tmr     = '0;
               nxt_overrun = 1'b0;
            end
         end
         pcs_pkg::ST_COUNT: begin
            if (guard_done) begin
               if (cnt_ff != cfg_ff.interv_m1) begin
                  nxt_cnt = cnt_ff + 3'h1;
               // lock two demands the rearm even when it was set after the stop
               end else if (full_ff && cfg_ff.rearm_lock != pcs_pkg::SET_1 &&
                            (need_rearm_ff || cfg_ff.rearm_lock == pcs_pkg::SET_2)) begin
                  nxt_st = pcs_pkg::ST_REARM;
               end else if (p2_ok) begin
                  nxt_st = pcs_pkg::ST_RUN;
               end else begin
                  nxt_st = pcs_pkg::ST_LOCK;
               end
            end
         end
         pcs_pkg::ST_REARM: begin
            if (rearm_done) begin
               nxt_st = p2_ok ? pcs_pkg::ST_RUN : pcs_pkg::ST_LOCK;
            end
         end
         pcs_pkg::ST_RUN: begin
            nxt_left = left_ff || !pins_ff.upper;
            if (guard_done && pins_ff.upper) begin
               nxt_unexp = 1'b1;
               nxt_st    = pcs_pkg::ST_LOCK;
            end else if (upper_rise && left_ff) begin
               nxt_st  = pcs_pkg::ST_COUNT;
               nxt_cnt = 3'h0;
               nxt_tmr = '0;
            end
         end
         default: nxt_st = pcs_pkg::ST_LOCK;
      endcase
      if (fail && st_ff != pcs_pkg::ST_LOCK) begin
         nxt_st         = pcs_pkg::ST_LOCK;
         nxt_full       = 1'b1;
         nxt_need_rearm = lock_stop;
         nxt_off        = cfg_ff.start_upper && !pins_ff.upper;
      end
      if (nxt_st == pcs_pkg::ST_RUN && st_ff != pcs_pkg::ST_RUN) begin
         nxt_full       = 1'b0;
         nxt_need_rearm = 1'b0;
         nxt_left       = 1'b0;
         nxt_unexp      = 1'b0;
      end
      nxt_permit  = (nxt_st == pcs_pkg::ST_RUN) && !fail;
      nxt_intv    = (nxt_st == pcs_pkg::ST_COUNT);
      nxt_rearm   = (nxt_st == pcs_pkg::ST_REARM);
      nxt_breach  = breach_cond && (st_ff == pcs_pkg::ST_RUN || breach_ff);
      nxt_fault   = cfg_ff.err_en && (nxt_overrun || nxt_unexp);
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         meta_ff       <= '0;
         pins_ff       <= '0;
         last_ff       <= '0;
         cfg_ff        <= pcs_pkg::CFG_RST;
         supv_ff       <= '0;
         rd_ff         <= 32'h00000000;
         div_ff        <= 18'h00000;
         st_ff         <= pcs_pkg::ST_LOCK;
         cnt_ff        <= 3'h0;
         full_ff       <= 1'b1;
         need_rearm_ff <= 1'b1;   // power-up counts as a stop outside the upper position
         left_ff       <= 1'b0;
         unexp_ff      <= 1'b0;
         tmr_ff        <= '0;
         permit_ff     <= 1'b0;
         intv_ff       <= 1'b0;
         rearm_ff      <= 1'b0;
         overrun_ff    <= 1'b0;
         breach_ff     <= 1'b0;
         off_ff        <= 1'b0;
         fault_ff      <= 1'b0;
      end else begin
         meta_ff       <= {permit1_in, permit2_in, guard_in, upper_in, launch_in, rearm_in};
         pins_ff       <= meta_ff;
         last_ff       <= pins_ff;
         cfg_ff        <= nxt_cfg;
         supv_ff       <= nxt_supv;
         rd_ff         <= nxt_rd;
         div_ff        <= nxt_div;
         st_ff         <= nxt_st;
         cnt_ff        <= nxt_cnt;
         full_ff       <= nxt_full;
         need_rearm_ff <= nxt_need_rearm;
         left_ff       <= nxt_left;
         unexp_ff      <= nxt_unexp;
         tmr_ff        <= nxt_tmr;
         permit_ff     <= nxt_permit;
         intv_ff       <= nxt_intv;
         rearm_ff      <= nxt_rearm;
         overrun_ff    <= nxt_overrun;
         breach_ff     <= nxt_breach;
         off_ff        <= nxt_off;
         fault_ff      <= nxt_fault;
      end
   end

   assign permit_out        = permit_ff;
   assign interv_needed_out = intv_ff;
   assign rearm_needed_out  = rearm_ff;
   assign overrun_out       = overrun_ff;
   assign breach_out        = breach_ff;
   assign off_pos_out       = off_ff;
   assign fault_out         = fault_ff;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   sequence upper_return_s;
      st_ff == pcs_pkg::ST_RUN && left_ff && upper_rise && !fail && !guard_done;
   endsequence

   permit_drop_a: assert property (!pins_ff.permit1 |=> !permit_ff)
      else $error("permit stayed high with primary permit low");
   breach_hold_a: assert property (breach_ff && breach_cond |=> breach_ff)
      else $error("guard breach released while its cause stands");
   fault_flag_a: assert property ($past(cfg_ff.err_en) && overrun_ff |-> fault_ff)
      else $error("fault indicator low during overrun");
   upper_cycle_a: assert property (upper_return_s |=>
                                   intv_ff && !permit_ff && cnt_ff == 3'h0)
      else $error("upper return did not restart intervention count");
   rearm_excl_a: assert property (rearm_ff |-> !permit_ff && !intv_ff)
      else $error("rearm needed overlaps permit");
   grant_cause_a: assert property ($rose(permit_ff) |->
                                   $past(guard_done) || $past(rearm_done))
      else $error("permit rose without an intervention or rearm");
   count_range_a: assert property (intv_ff |-> cnt_ff <= cfg_ff.interv_m1)
      else $error("intervention count beyond setting");
   overrun_set_a: assert property (st_ff == pcs_pkg::ST_COUNT && over_now |=>
                                   overrun_ff)
      else $error("supervision overrun not flagged");
   lock_rearm_a: assert property (st_ff == pcs_pkg::ST_COUNT && guard_done && full_ff &&
                                  cnt_ff == cfg_ff.interv_m1 && !fail &&
                                  cfg_ff.rearm_lock == pcs_pkg::SET_2 |=> rearm_ff)
      else $error("complete sequence skipped rearm");
endmodule // pcs_monitor

// ### pcs_press_model.sv
// partner model: optical guard and press stroke controller on the monitor pins
// assumes the bench calls its tasks; pins change just after a rising clock edge
`timescale 1ns/10ps
module pcs_press_model #(
   parameter int unsigned MS_P = 4
) (
   // clock
   input  wire logic clock_in,
   // pins: permit1, permit2, guard, upper, launch, rearm
   output logic [5:0] pins_out
);
   initial begin
      pins_out = 6'h00;
   end
   task automatic hold_ms(input int ms);
      repeat (ms * MS_P) @(posedge clock_in);
   endtask
   // level change, then a short settle so the monitor has seen it
   task automatic set(input int i, input logic v);
      @(posedge clock_in);
      pins_out[i] <= v;
      repeat (8) @(posedge clock_in);
   endtask
   // one high-low-high at the guard, low phase ms long
   task automatic intervene(input int ms);
      set(3, 1'b0);
      hold_ms(ms);
      set(3, 1'b1);
      hold_ms(2);
   endtask
   // low-high-low rearm pulse; short ones are sent on purpose to be ignored
   task automatic rearm_pulse(input int ms);
      set(0, 1'b1);
      hold_ms(ms);
      set(0, 1'b0);
      hold_ms(2);
   endtask
endmodule // pcs_press_model

// ### tb.sv
// testbench of the press cyclic start monitor against an integer state model
// assumes a 4 cycle millisecond tick so 100 ms is 400 clocks
`timescale 1ns/10ps
module tb;
   localparam int unsigned MSC = 4;
   localparam int P1 = 5, P2 = 4, GD = 3, UP = 2, LN = 1;
   logic        clock_in   = 1'b0;
   logic        rst_in     = 1'b1;
   logic        psel_in    = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in  = 1'b0;
   logic [11:0] paddr_in   = 12'h000;
   logic [31:0] pwdata_in  = 32'h0;
   wire  [31:0] prdata_out;
   wire         pready_out;
   wire         pslverr_out;
   wire  [5:0]  pins;
   wire  [6:0]  outs;   // permit, need, rearm, overrun, breach, off_pos, fault
   int          fails = 0;
   int          num_checks = 0;
   int          m_st = 0, m_cnt = 0, m_n = 1, m_lock = 1, m_dem = 1, m_p2 = 1;
   int          m_over = 0, m_br = 0, m_off = 0, m_flt = 0;
   always #2 clock_in = ~clock_in;
   pcs_press_model #(.MS_P(MSC)) u_press (.clock_in(clock_in), .pins_out(pins));
   pcs_monitor #(.MS_CYCLES_P(MSC)) u_dut (
      .clock_in(clock_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .permit1_in(pins[5]), .permit2_in(pins[4]), .guard_in(pins[3]), .upper_in(pins[2]),
      .launch_in(pins[1]), .rearm_in(pins[0]), .permit_out(outs[6]),
      .interv_needed_out(outs[5]), .rearm_needed_out(outs[4]), .overrun_out(outs[3]),
      .breach_out(outs[2]), .off_pos_out(outs[1]), .fault_out(outs[0]));
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   // bounded wait until the outputs under mask match the model
   task automatic sync(input logic [6:0] mask, input int lim, input string what);
      logic [6:0] e;
      int k;
      e = {m_st == 3, m_st == 1, m_st == 2, m_over != 0, m_br != 0, m_off != 0, m_flt != 0};
      e = e & mask;
      k = 0;
      while ((outs & mask) !== e && k < lim) begin
         @(posedge clock_in);
         k++;
      end
      check({25'h0, outs & mask}, {25'h0, e}, what);
      if ((outs & mask) !== e) conclude();
   endtask
   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int k;
      k = 0;
      @(posedge clock_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      @(posedge clock_in);
      while (pready_out !== 1'b1 && k < 50) begin
         @(posedge clock_in);
         k++;
      end
      q = prdata_out;
      e = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
      if (k >= 50) begin
         fails++;
         conclude();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(a, 1'b1, d, q, e);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] q;
      logic e;
      apb(a, 1'b0, 32'h0, q, e);
      check(q, x, "read data");
      check({31'h0, e}, {31'h0, xe}, "read error");
   endtask
   task automatic interv(input int ms);
      u_press.intervene(ms);
      if (ms >= 100 && m_st == 1) begin
         m_cnt++;
         if (m_cnt == m_n) begin
            m_cnt = 0;
            if (m_dem != 0 && m_lock != 1) m_st = 2;
            else if (m_p2 == 2 && pins[P2] !== 1'b1) m_st = 1;
            else m_st = 3;
            m_dem = 0;
         end
      end else if (m_st == 3) begin
         m_st = 1;   // unexpected one in run: relock, pins still allow a new count
         m_dem = 1;
      end
      sync(7'h70, 40, "intervention");
   endtask
   task automatic rearm(input int ms);
      u_press.rearm_pulse(ms);
      if (ms >= 100 && ms <= 30000 && m_st == 2) m_st = 3;
      sync(7'h70, 40, "rearm");
   endtask
   initial begin
      void'($urandom(50599));
      repeat (10) @(posedge clock_in);
      rst_in <= 1'b0;
      sync(7'h7f, 10, "reset");
      rd(12'h000, 32'h0000_0128, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      rd(12'h008, 32'h0000_0800, 1'b0);
      rd(12'hffc, 32'h0, 1'b1);
      wr(12'h000, 32'h0000_10a8);
      u_press.set(P1, 1'b1);
      u_press.set(GD, 1'b1);
      u_press.set(UP, 1'b1);
      m_st = 1;
      sync(7'h7f, 20, "armed");
      interv(50);
      interv(110 + $urandom_range(30));
      u_press.set(UP, 1'b0);
      u_press.set(UP, 1'b1);
      m_st = 1;
      sync(7'h7f, 20, "top again");
      interv(120);
      u_press.set(P1, 1'b0);
      m_st = 0;
      sync(7'h40, 8, "permit loss");
      // random count per start with rearm always locked
      m_n = $urandom_range(1, 8);
      m_lock = 2;
      m_dem = 1;
      wr(12'h000, 32'h0000_1128 | (m_n - 1));
      u_press.set(P1, 1'b1);
      m_st = 1;
      repeat (m_n) interv(110 + $urandom_range(40));
      rearm(50);
      rearm(120 + $urandom_range(50));
      interv(120);
      check({31'h0, outs[0]}, 32'h1, "unexpected fault");
      u_press.set(P1, 1'b0);
      m_st = 0;
      m_n = 1;
      m_lock = 1;
      wr(12'h000, 32'h0000_10a8);
      u_press.set(P1, 1'b1);
      m_st = 1;
      interv(120);
      u_press.set(UP, 1'b0);
      u_press.set(GD, 1'b0);
      m_st = 0;
      m_br = 1;
      sync(7'h7f, 20, "breach");
      u_press.set(GD, 1'b1);
      m_br = 0;
      m_st = 1;
      sync(7'h7f, 20, "breach gone");
      interv(120);
      u_press.set(UP, 1'b1);
      m_st = 1;
      wr(12'h004, 32'h0000_0032);
      rd(12'h004, 32'h0000_0032, 1'b0);
      u_press.set(GD, 1'b0);
      m_st = 0;
      m_over = 1;
      m_flt = 1;
      sync(7'h7f, 600, "overrun");
      wr(12'h004, 32'h0);
      u_press.set(GD, 1'b1);
      m_over = 0;
      m_flt = 0;
      m_st = 1;
      sync(7'h7f, 20, "overrun cleared");
      // the stop must fall away from the top for the start position check to bite
      wr(12'h000, 32'h0000_18a8);
      u_press.set(UP, 1'b0);
      u_press.set(P1, 1'b0);
      u_press.set(P1, 1'b1);
      m_st = 0;
      m_off = 1;
      sync(7'h7f, 20, "off top");
      u_press.set(UP, 1'b1);
      m_off = 0;
      m_st = 1;
      sync(7'h7f, 20, "back at top");
      m_p2 = 2;
      wr(12'h000, 32'h0000_18b0);
      interv(120);
      u_press.set(P2, 1'b1);
      interv(120);
      // launch mutes the breach and lock three spares the rearm while launching
      m_lock = 3;
      m_dem = 0;
      wr(12'h000, 32'h0000_11d0);
      u_press.set(LN, 1'b1);
      u_press.set(UP, 1'b0);
      u_press.set(GD, 1'b0);
      sync(7'h7f, 20, "launch muted");
      u_press.set(GD, 1'b1);
      u_press.set(P1, 1'b0);
      u_press.set(P1, 1'b1);
      m_st = 1;
      interv(120);
      u_press.set(LN, 1'b0);
      u_press.set(P1, 1'b0);
      u_press.set(P1, 1'b1);
      m_st = 1;
      m_dem = 1;
      interv(120);
      rearm(120);
      conclude();
   end
endmodule // tb
